// file: hdl/pcm_main_counter.sv
// main time-base counter of the counter array with an axi4-lite register slave
`timescale 1ns/1ns
module pcm_main_counter
    import pcm_pkg::*;
#(
    parameter int ADDR_W = 18
)(
    input  wire  logic                sys_clk,
    input  wire  logic                rst,
    input  wire  logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire  logic [2:0]          s_axi_awprot,
    input  wire  logic                s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire  logic [31:0]         s_axi_wdata,
    input  wire  logic [3:0]          s_axi_wstrb,
    input  wire  logic                s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire  logic                s_axi_bready,
    input  wire  logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire  logic [2:0]          s_axi_arprot,
    input  wire  logic                s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire  logic                s_axi_rready,
    input  wire  logic                idle_mode,
    input  wire  logic                comparator_event,
    input  wire  logic [5:0]          channel_irq,
    input  wire  logic [5:0]          channel_irq_enable,
    output logic [15:0]               count_value,
    output logic                      count_tick,
    output logic                      overflow_pulse,
    output logic                      irq
);

    // the highest register index must fit the address
    if (ADDR_W < IDX_W + IDX_LSB)
    begin : g_chk
        $error("ADDR_W too small for register map");
    end

    typedef struct packed {
        logic [7:0]       mode;
        logic [7:0]       flags;
        logic [7:0]       prescale;
        logic [7:0]       div;
        logic [15:0]      count;
        logic [7:0]       rld_hi;
        logic [7:0]       rld_lo;
        logic [15:0]      rld_act;
        logic [15:0]      cmp_buf;
        logic [15:0]      cmp_act;
        logic [15:0]      snap;
        logic             aw_got;
        logic [IDX_W-1:0] aw_idx;
        logic             w_got;
        logic [7:0]       wdata;
        logic             wstrb0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
    } pcm_state_t;

    pcm_state_t st_q;
    pcm_state_t st_d;

    logic        adv;
    logic        tick;
    logic        ovf_ev;
    logic        cmp_ev;
    logic [15:0] cnt_nx;
    logic        ar_hs;
    logic [IDX_W-1:0] ar_idx;
    logic        do_wr;
    logic        wr_hit;

    // counting gate: enable first, then the idle gate
    assign adv = st_q.mode[B_ENABLE]                                   // [RL3]
        && !(st_q.mode[B_IDLE_GATE] && idle_mode);                     // [RL2]

    // one tick every prescale+1 system clocks
    assign tick = adv && (st_q.div == st_q.prescale);                  // [RL1]

    // overflow point: low byte wrap or full word wrap
    assign ovf_ev = tick && (st_q.mode[B_BYTE_OVF]
        ? (st_q.count[7:0] == BYTE_TOP)                                // [RL6]
        : (st_q.count == WORD_TOP));                                   // [RL7]

    // next count; narrow width keeps the high byte still
    always_comb
    begin
        cnt_nx = st_q.count;
        if (ovf_ev && st_q.mode[B_RELOAD])
        begin
            if (st_q.mode[B_NARROW])                                   // [RL5]
                cnt_nx[7:0] = st_q.rld_act[7:0];                       // [RL4]
            else
                cnt_nx = st_q.rld_act;                                 // [RL4]
        end
        else if (st_q.mode[B_NARROW])
            cnt_nx[7:0] = st_q.count[7:0] + 8'h01;                     // [RL5]
        else
            cnt_nx = st_q.count + 16'h0001;
    end

    // compare hit on arrival at the active compare value
    assign cmp_ev = tick && (cnt_nx == st_q.cmp_act);                  // [RL10]

    assign ar_hs  = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[IDX_LSB +: IDX_W];
    assign do_wr  = st_q.aw_got && st_q.w_got;

    // write decode; count bytes are mapped but ignore writes
    always_comb
    begin
        unique case (st_q.aw_idx)
            IDX_MODE, IDX_FLAGS, IDX_PRESCALE, IDX_CNT_HI, IDX_CNT_LO,
            IDX_RLD_HI, IDX_RLD_LO, IDX_SNAP_HI, IDX_SNAP_LO:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // read mux: bit 8 marks a mapped index
    function automatic logic [8:0] rd_mux(
        input logic [IDX_W-1:0] idx,
        input pcm_state_t       s
    );
        logic [8:0] r;
        r = {1'b1, RST_BYTE};
        unique case (idx)
            IDX_MODE:     r[7:0] = s.mode;
            IDX_FLAGS:    r[7:0] = s.flags;
            IDX_PRESCALE: r[7:0] = s.prescale;
            IDX_CNT_HI:   r[7:0] = s.count[15:8];
            IDX_CNT_LO:   r[7:0] = s.count[7:0];
            IDX_RLD_HI:   r[7:0] = s.rld_hi;
            IDX_RLD_LO:   r[7:0] = s.rld_lo;
            IDX_SNAP_HI:  r[7:0] = s.snap[15:8];
            IDX_SNAP_LO:  r[7:0] = s.snap[7:0];
            default:      r = {1'b0, RST_BYTE};
        endcase
        return r;
    endfunction

    // next state of the whole block
    always_comb
    begin
        logic [8:0] rd;
        logic [7:0] set_v;
        rd    = rd_mux(ar_idx, st_q);
        set_v = {ovf_ev, cmp_ev, channel_irq};
        st_d  = st_q;

        // prescaler restarts whenever counting is gated off
        if (!adv || tick)
            st_d.div = RST_BYTE;
        else
            st_d.div = st_q.div + 8'h01;

        // counter and its double buffers
        if (!st_q.mode[B_ENABLE])
        begin
            st_d.count   = RST_WORD;                                   // [RL8]
            st_d.rld_act = {st_q.rld_hi, st_q.rld_lo};                 // [RL8]
            st_d.cmp_act = st_q.cmp_buf;                               // [RL11]
        end
        else if (tick)
        begin
            st_d.count = cnt_nx;
            // new reload and compare values only take hold at overflow
            if (ovf_ev)
            begin
                st_d.rld_act = {st_q.rld_hi, st_q.rld_lo};             // [RL19]
                st_d.cmp_act = st_q.cmp_buf;                           // [RL11]
            end
        end

        // snapshot: low byte read or enabled comparator event
        if ((ar_hs && ar_idx == IDX_CNT_LO)                            // [RL18]
            || (comparator_event && st_q.mode[B_CMP_TRIG]))            // [RL13]
            st_d.snap = st_q.count;                                    // [RL12]

        // write address and data may come in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = s_axi_awaddr[IDX_LSB +: IDX_W];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_d.w_got  = 1'b1;
            st_d.wdata  = s_axi_wdata[7:0];
            st_d.wstrb0 = s_axi_wstrb[0];
        end

        // perform the write once both halves are held
        if (do_wr)
        begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = wr_hit ? RESP_OK : RESP_DEC;
            if (st_q.wstrb0)
            begin
                unique case (st_q.aw_idx)
                    IDX_MODE:     st_d.mode        = st_q.wdata;
                    IDX_FLAGS:    st_d.flags       = st_q.wdata;
                    IDX_PRESCALE: st_d.prescale    = st_q.wdata;
                    IDX_RLD_HI:   st_d.rld_hi      = st_q.wdata;       // [RL19]
                    IDX_RLD_LO:   st_d.rld_lo      = st_q.wdata;       // [RL19]
                    IDX_SNAP_HI:  st_d.cmp_buf[15:8] = st_q.wdata;     // [RL11]
                    IDX_SNAP_LO:  st_d.cmp_buf[7:0]  = st_q.wdata;     // [RL11]
                    default:      st_d.mode        = st_q.mode;
                endcase
            end
        end
        else if (st_q.bvalid && s_axi_bready)
            st_d.bvalid = 1'b0;

        // hardware sets win over a software clear in the same cycle
        st_d.flags = st_d.flags | set_v;                    // [RL14] [RL15] [RL16]

        // read answer one edge after the address is taken
        if (ar_hs)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd[7:0];
            st_d.rresp  = rd[8] ? RESP_OK : RESP_DEC;
        end
        else if (st_q.rvalid && s_axi_rready)
            st_d.rvalid = 1'b0;
    end

    // single state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // bus handshakes; one write and one read in flight
    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = {24'h000000, st_q.rdata};

    // time base to the six channels
    assign count_value    = st_q.count;                                // [RL17]
    assign count_tick     = tick;
    assign overflow_pulse = ovf_ev;

    // one request line; channel enables live in the channel modules
    assign irq = (st_q.flags[B_OVF_FLAG] && st_q.mode[B_OVF_IRQ])      // [RL9]
        || (st_q.flags[B_CMP_FLAG] && st_q.mode[B_CMP_IRQ])            // [RL10]
        || (|(st_q.flags[NUM_CHAN-1:0] & channel_irq_enable));         // [RL20]

    // ------- checks -------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_tick_period: assert property ( // [RL1]
        (adv && !tick) |=> st_q.div == $past(st_q.div) + 8'h01)
        else $error("prescaler skipped a step");

    a_halt_holds: assert property ( // [RL2]
        (st_q.mode[B_ENABLE] && st_q.mode[B_IDLE_GATE] && idle_mode)
        ##0 ($stable(st_q.mode) && $stable(idle_mode)) [*2]
        |-> $stable(st_q.count))
        else $error("count moved while idle gated");

    a_disable_zero: assert property ( // [RL3]
        !st_q.mode[B_ENABLE] |=> st_q.count == RST_WORD)
        else $error("count not zero while disabled");

    a_reload_word: assert property ( // [RL4]
        (ovf_ev && st_q.mode[B_RELOAD] && !st_q.mode[B_NARROW])
        |=> st_q.count == $past(st_q.rld_act))
        else $error("reload value not loaded");

    a_narrow_high: assert property ( // [RL5]
        (tick && st_q.mode[B_NARROW]) |=> $stable(st_q.count[15:8]))
        else $error("high byte moved in narrow width");

    a_byte_wrap: assert property ( // [RL6]
        (tick && st_q.mode[B_BYTE_OVF] && st_q.count[7:0] == BYTE_TOP)
        |=> st_q.flags[B_OVF_FLAG])
        else $error("byte wrap did not flag overflow");

    a_word_wrap: assert property ( // [RL7]
        (ovf_ev && !st_q.mode[B_BYTE_OVF]) |-> st_q.count == WORD_TOP)
        else $error("overflow away from full wrap");

    a_cmp_flag: assert property ( // [RL15]
        cmp_ev |=> st_q.flags[B_CMP_FLAG] && st_q.count == $past(st_q.cmp_act))
        else $error("compare match not flagged");

    a_chan_flags: assert property ( // [RL16]
        |channel_irq |=> (st_q.flags[NUM_CHAN-1:0] & $past(channel_irq)) == $past(channel_irq))
        else $error("channel flag lost");

    a_ovf_irq: assert property ( // [RL9]
        (st_q.flags[B_OVF_FLAG] && st_q.mode[B_OVF_IRQ]) |-> irq)
        else $error("overflow interrupt missing");

    a_snap_read: assert property ( // [RL18]
        (ar_hs && ar_idx == IDX_CNT_LO) |=> st_q.snap == $past(st_q.count))
        else $error("low byte read did not snapshot");

    a_snap_cmp: assert property ( // [RL13]
        (!comparator_event || !st_q.mode[B_CMP_TRIG])
        && !(ar_hs && ar_idx == IDX_CNT_LO) |=> $stable(st_q.snap))
        else $error("snapshot taken without trigger");

    a_read_resp: assert property (
        ar_hs |=> s_axi_rvalid)
        else $error("read answer late");

    a_tick_restart: assert property ( // [RL1]
        (tick || !adv) |=> st_q.div == RST_BYTE)
        else $error("prescaler did not restart");

    a_gate_no_tick: assert property ( // [RL2]
        (st_q.mode[B_IDLE_GATE] && idle_mode) |-> !tick)
        else $error("tick while idle gated");

    a_narrow_reload: assert property ( // [RL4]
        (ovf_ev && st_q.mode[B_RELOAD] && st_q.mode[B_NARROW])
        |=> st_q.count[7:0] == $past(st_q.rld_act[7:0]) && $stable(st_q.count[15:8]))
        else $error("narrow reload wrong");

    a_word_flag: assert property ( // [RL7]
        (tick && !st_q.mode[B_BYTE_OVF] && st_q.count == WORD_TOP) |=> st_q.flags[B_OVF_FLAG])
        else $error("full wrap did not flag overflow");

    // active copies only move at overflow or while disabled
    a_cmp_hold: assert property ( // [RL11]
        (st_q.mode[B_ENABLE] && !ovf_ev) |=> $stable(st_q.cmp_act))
        else $error("compare value changed between overflows");

    a_rld_hold: assert property ( // [RL19]
        (st_q.mode[B_ENABLE] && !ovf_ev) |=> $stable(st_q.rld_act))
        else $error("reload value changed between overflows");

    // hardware never clears a flag; only a register write may
    a_ovf_sticky: assert property ( // [RL14]
        (st_q.flags[B_OVF_FLAG] && !do_wr) |=> st_q.flags[B_OVF_FLAG])
        else $error("overflow flag cleared by hardware");

    a_cmp_sticky: assert property ( // [RL15]
        (st_q.flags[B_CMP_FLAG] && !do_wr) |=> st_q.flags[B_CMP_FLAG])
        else $error("compare flag cleared by hardware");

    a_chan_sticky: assert property ( // [RL16]
        !do_wr |=> (st_q.flags[NUM_CHAN-1:0] & $past(st_q.flags[NUM_CHAN-1:0]))
            == $past(st_q.flags[NUM_CHAN-1:0]))
        else $error("channel flag cleared by hardware");

    a_irq_quiet: assert property ( // [RL9] [RL20]
        (!st_q.mode[B_OVF_IRQ] && !st_q.mode[B_CMP_IRQ]
        && !(|(st_q.flags[NUM_CHAN-1:0] & channel_irq_enable))) |-> !irq)
        else $error("interrupt without enabled flag");

    a_snap_trig: assert property ( // [RL13]
        (comparator_event && st_q.mode[B_CMP_TRIG]) |=> st_q.snap == $past(st_q.count))
        else $error("comparator event did not snapshot");

    a_write_resp: assert property (
        do_wr |=> s_axi_bvalid)
        else $error("write answer late");

endmodule

// file: hdl/pcm_pkg.sv
// constants and register map of the counter-array main time base
// Summary of operation
// RL1: counter clock is system clock divided by prescale value plus one.
// RL2: idle gate set halts counting in processor idle mode; clear keeps counting.
// RL3: counter advances only while counter enable is one.
// RL4: auto-reload loads reload bytes on overflow, low byte only when narrow.
// RL5: narrow width select makes counter 8 bits; software then sets byte overflow.
// RL6: byte overflow enable flags overflow at every low byte wrap, both widths.
// RL7: byte overflow enable clear flags overflow only at full 16-bit wrap.
// RL8: counter enable clear zeroes count and loads double buffer from reload bytes.
// RL9: overflow interrupt only when overflow interrupt enable is set.
// RL10: compare interrupt when count equals compare pair and compare enable set.
// RL11: compare value is double-buffered, taking effect at overflow or disable.
// RL12: snapshot copies count on software read or hardware trigger.
// RL13: comparator trigger enable lets comparator event capture count into snapshot.
// RL14: overflow flag bit 7 set on overflow; only software clears it.
// RL15: compare flag bit 6 set on compare match; only software clears it.
// RL16: channel flags bits 5 to 0 set by channel interrupts; software clears.
// RL17: six channels share the main count value as common time base.
// RL18: reading count low byte copies full count into snapshot bytes.
// RL19: separate reload high and low bytes, used only in auto-reload.
// RL20: interrupt request while any flag is set with its enable.
package pcm_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE     = 16'h00D1;
    localparam logic [15:0] IDX_FLAGS    = 16'h00E1;
    localparam logic [15:0] IDX_PRESCALE = 16'hA0A5;
    localparam logic [15:0] IDX_CNT_HI   = 16'h00E9;
    localparam logic [15:0] IDX_CNT_LO   = 16'h00D9;
    localparam logic [15:0] IDX_RLD_HI   = 16'hA0A7;
    localparam logic [15:0] IDX_RLD_LO   = 16'hA0A6;
    localparam logic [15:0] IDX_SNAP_HI  = 16'h00F3;
    localparam logic [15:0] IDX_SNAP_LO  = 16'h00F2;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_W        = 16;
    // mode control bit positions
    localparam int B_IDLE_GATE  = 7;
    localparam int B_RELOAD     = 6;
    localparam int B_NARROW     = 5;
    localparam int B_BYTE_OVF   = 4;
    localparam int B_ENABLE     = 3;
    localparam int B_OVF_IRQ    = 2;
    localparam int B_CMP_IRQ    = 1;
    localparam int B_CMP_TRIG   = 0;
    // flag register bit positions
    localparam int B_OVF_FLAG   = 7;
    localparam int B_CMP_FLAG   = 6;
    localparam int NUM_CHAN     = 6;
    // values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  BYTE_TOP  = 8'hFF;
    localparam logic [15:0] WORD_TOP  = 16'hFFFF;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_DEC  = 2'h3;
endpackage

// file: dv/pcm_chan_model.sv
// behavioural model of the six capture/compare channels on the main time base
`timescale 1ns/1ns
module pcm_chan_model
    import pcm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] count_value,
    input  wire logic        count_tick,
    output logic      [5:0]  channel_irq
);
    // each channel matches at its own count, so the flags arrive one by one;
    // a match is judged on the count seen in the tick cycle, as real channels do
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            channel_irq[i] <= !rst && count_tick && (count_value == 16'(8 * i + 3));
        end
    end
endmodule

// file: dv/tb.sv
// self-checking bench: register slave, prescaler, gating, overflow, compare, snapshot
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %0t mismatch got %h want %h", $time, (got), (exp)); end end
module tb
    import pcm_pkg::*;
();
    typedef struct packed {logic [1:0] resp; logic [7:0] data;} pcm_exp_t;
    localparam logic [7:0]  M_EN   = 8'(1 << B_ENABLE);
    localparam logic [7:0]  M_GATE = 8'(1 << B_IDLE_GATE);
    localparam logic [7:0]  M_RLD  = 8'(1 << B_RELOAD);
    localparam logic [7:0]  M_NAR  = 8'(1 << B_NARROW);
    localparam logic [7:0]  M_BOVF = 8'(1 << B_BYTE_OVF);
    localparam logic [7:0]  M_OVFI = 8'(1 << B_OVF_IRQ);
    localparam logic [7:0]  M_CMPI = 8'(1 << B_CMP_IRQ);
    localparam logic [7:0]  M_TRIG = 8'(1 << B_CMP_TRIG);
    localparam logic [15:0] RST_REGS [5] = '{IDX_MODE, IDX_FLAGS, IDX_PRESCALE,
                                             IDX_RLD_HI, IDX_RLD_LO};
    logic        sys_clk, rst, idle_mode, comparator_event, count_tick, irq, ovf_p;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br;
    logic [5:0]  channel_irq, ch_en;
    logic [15:0] count_value, v;
    logic [7:0]  p;
    int          tests_run, miscompares, cycles, n;
    pcm_exp_t    e, rq[$];
    logic [1:0]  bq[$];

    pcm_main_counter u_dut (
        .sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .idle_mode, .comparator_event, .channel_irq, .channel_irq_enable(ch_en),
        .count_value, .count_tick, .overflow_pulse(ovf_p), .irq);

    pcm_chan_model u_chan (.sys_clk, .rst, .count_value, .count_tick, .channel_irq);

    always #10 sys_clk = ~sys_clk;

    // ready is judged at the falling edge so the handshake edge is known in advance
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OK);
        logic ha, hw, ta, tw;
        begin
            bq.push_back(r);
            ha = 1'b0;
            hw = 1'b0;
            @(posedge sys_clk);
            s_axi_awaddr  <= {a, 2'b00};
            s_axi_wdata   <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            while (!(ha && hw))
            begin
                @(negedge sys_clk);
                ta = !ha && s_axi_awready;
                tw = !hw && s_axi_wready;
                @(posedge sys_clk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                ha |= ta;
                hw |= tw;
            end
            do @(negedge sys_clk); while (!s_axi_bvalid);
            @(posedge sys_clk);
            s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OK);
        begin
            rq.push_back('{r, d});
            @(posedge sys_clk);
            s_axi_araddr  <= {a, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            do @(negedge sys_clk); while (!s_axi_arready);
            @(posedge sys_clk);
            s_axi_arvalid <= 1'b0;
            do @(negedge sys_clk); while (!s_axi_rvalid);
            @(posedge sys_clk);
            s_axi_rready <= 1'b0;
        end
    endtask

    task automatic wait_cnt(input logic [15:0] x);
        do @(negedge sys_clk); while (count_value !== x);
    endtask

    task automatic chk_irq(input logic x);
        begin
            @(negedge sys_clk);
            `CHK(irq, x)
        end
    endtask

    task automatic pulse_cmp();
        begin
            @(posedge sys_clk);
            comparator_event <= 1'b1;
            @(posedge sys_clk);
            comparator_event <= 1'b0;
        end
    endtask

    task automatic conclude();
        begin
            $display("comparisons %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // answers are checked against the oldest note of their channel
    always @(negedge sys_clk)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            br = bq.pop_front();
            `CHK(s_axi_bresp, br)
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rq.pop_front();
            `CHK(s_axi_rresp, e.resp)
            `CHK(s_axi_rdata, {24'h000000, e.data})
        end
    end

    // hang guard; the whole run needs under two thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {idle_mode, comparator_event, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        void'($urandom(32'h24FD));
        p = 8'($urandom_range(6, 1));
        ch_en = 6'($urandom_range(63, 1));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd(RST_REGS[i], RST_BYTE);
        wr(16'h0123, 8'h55, RESP_DEC);
        rd(16'h0123, 8'h00, RESP_DEC);
        wr(IDX_PRESCALE, p);
        rd(IDX_PRESCALE, p);
        repeat (20) @(negedge sys_clk);
        `CHK(count_value, RST_WORD)
        // tick spacing is measured between two count changes
        wr(IDX_MODE, M_EN);
        @(negedge sys_clk);
        v = count_value;
        do @(negedge sys_clk); while (count_value === v);
        v = count_value;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (count_value === v);
        `CHK(n, int'(p) + 1)
        wr(IDX_MODE, M_EN | M_GATE);
        idle_mode <= 1'b1;
        repeat (2) @(negedge sys_clk);
        v = count_value;
        repeat (3 * p + 3) @(negedge sys_clk);
        `CHK(count_value, v)
        wr(IDX_MODE, M_EN);
        repeat (3 * p + 3) @(negedge sys_clk);
        `CHK(count_value === v, 1'b0)
        // frozen count makes the snapshot value exact
        wr(IDX_MODE, M_EN | M_GATE);
        @(negedge sys_clk);
        v = count_value;
        rd(IDX_CNT_HI, v[15:8]);
        rd(IDX_CNT_LO, v[7:0]);
        rd(IDX_SNAP_HI, v[15:8]);
        rd(IDX_SNAP_LO, v[7:0]);
        wr(IDX_MODE, M_EN);
        repeat (2 * p + 2) @(posedge sys_clk);
        wr(IDX_MODE, M_EN | M_GATE);
        pulse_cmp();
        rd(IDX_SNAP_HI, v[15:8]);
        rd(IDX_SNAP_LO, v[7:0]);
        wr(IDX_MODE, M_EN | M_GATE | M_TRIG);
        @(negedge sys_clk);
        v = count_value;
        pulse_cmp();
        rd(IDX_SNAP_HI, v[15:8]);
        rd(IDX_SNAP_LO, v[7:0]);
        idle_mode <= 1'b0;
        wr(IDX_MODE, 8'h00);
        rd(IDX_CNT_LO, RST_BYTE);
        rd(IDX_CNT_HI, RST_BYTE);
        // compare at 0x0030, then a new value that must wait for an overflow
        wr(IDX_PRESCALE, 8'h00);
        wr(IDX_SNAP_HI, 8'h00);
        wr(IDX_SNAP_LO, 8'h30);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_MODE, M_EN | M_CMPI);
        wait_cnt(16'h0031);
        rd(IDX_FLAGS, 8'h7F);
        chk_irq(1'b1);
        wr(IDX_SNAP_LO, 8'h90);
        wr(IDX_FLAGS, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        chk_irq(1'b0);
        wr(IDX_FLAGS, 8'h3F);
        chk_irq(1'b1);
        ch_en <= 6'h00;
        chk_irq(1'b0);
        wr(IDX_FLAGS, 8'h00);
        wait_cnt(16'h0091);
        rd(IDX_FLAGS, 8'h00);
        // byte overflow with full reload, then full-width overflow only
        wr(IDX_MODE, 8'h00);
        wr(IDX_RLD_HI, 8'hFD);
        wr(IDX_RLD_LO, 8'hF0);
        wr(IDX_MODE, M_EN | M_RLD | M_BOVF | M_OVFI);
        wait_cnt(16'hFDF0);
        rd(IDX_FLAGS, 8'hFF);
        chk_irq(1'b1);
        wr(IDX_MODE, M_EN | M_RLD);
        chk_irq(1'b0);
        wait_cnt(16'hFE10);
        wr(IDX_FLAGS, 8'h00);
        wait_cnt(16'hFEFF);
        `CHK(ovf_p, 1'b0)
        wait_cnt(16'hFF10);
        rd(IDX_FLAGS, 8'h00);
        wait_cnt(16'hFDF0);
        rd(IDX_FLAGS, 8'h80);
        // narrow counter reloads only its low byte
        wr(IDX_MODE, 8'h00);
        wr(IDX_RLD_HI, 8'h12);
        wr(IDX_MODE, M_EN | M_RLD | M_NAR | M_BOVF);
        wait_cnt(16'h00FF);
        `CHK(count_tick, 1'b1)
        `CHK(ovf_p, 1'b1)
        @(negedge sys_clk);
        `CHK(count_value, 16'h00F0)
        conclude();
    end
endmodule
